// ---- fcs_pkg.sv ----
// Purpose: shared constants and types of the flash command sequencer
// Assumes: 100 MHz system clock, 16-bit command bus, word-wide array
// Notes:   command codes are compared on the low byte only
package fcs_pkg;

  // clock and auto operation timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PROG_TIME_NS   = 1000;
  localparam int ERASE_TIME_NS  = 20000;
  localparam int PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES   = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 16;

  // array geometry (byte addressing, even addresses only)
  localparam int ADDR_W         = 12;
  localparam int DATA_W         = 16;
  localparam int BLOCK_SHIFT    = 9;
  localparam int BLOCK_W        = ADDR_W - BLOCK_SHIFT;
  localparam int WORDS          = 1 << (ADDR_W - 1);
  localparam int BLOCK_WORDS    = 1 << (BLOCK_SHIFT - 1);
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // command codes, low byte of the write data
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;

  // status byte layout and reset values
  localparam int STAT_READY_BIT  = 7;
  localparam int STAT_EFAIL_BIT  = 5;
  localparam int STAT_PFAIL_BIT  = 4;
  localparam logic READY_RESET   = 1'b1;
  localparam logic FAIL_RESET    = 1'b0;

  typedef enum logic [2:0] {
    FCS_IDLE       = 3'b000,
    FCS_PROG_DATA  = 3'b001,
    FCS_ERASE_CONF = 3'b010,
    FCS_BUSY       = 3'b011
  } fcs_state_t;

  typedef enum logic [0:0] {
    FCS_RD_ARRAY  = 1'b0,
    FCS_RD_STATUS = 1'b1
  } fcs_read_mode_t;

endpackage

// ---- fcs_op_if.sv ----
// Purpose: carrier between the sequencer and the flash array
// Assumes: all signals on the sequencer clock
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
interface fcs_op_if;
  import fcs_pkg::*;
  logic                start;
  logic                erase;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [ADDR_W-1:0]   raddr;
  logic [DATA_W-1:0]   rdata;
  logic                fail;

  modport seq (output start, erase, addr, wdata, raddr, input rdata, fail);
  modport arr (input start, erase, addr, wdata, raddr, output rdata, fail);
endinterface

// ---- fcs_op_timer.sv ----
// Purpose: counts the length of one auto program or auto erase
// Assumes: start is ignored while a count is running
// Notes:   done pulses for one cycle at the end of the count
`timescale 1ns/1ps
module fcs_op_timer
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  input  wire logic is_erase,
  output logic      done
);

  logic [TIMER_W-1:0] count_q;
  logic               run_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q   <= 1'b0;
      count_q <= '0;
    end else if (!run_q && start) begin
      run_q   <= 1'b1;
      count_q <= is_erase ? TIMER_W'(ERASE_CYCLES - 1) : TIMER_W'(PROG_CYCLES - 1);
    end else if (run_q && count_q == '0) begin
      run_q   <= 1'b0;
    end else if (run_q) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign done = run_q && (count_q == '0);

endmodule

// ---- fcs_flash_array.sv ----
// Purpose: word-wide flash array with program and block erase
// Assumes: program can only clear bits; erased words read all ones
// Notes:   verify fails when a word not erased is programmed again
`timescale 1ns/1ps
module fcs_flash_array
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // operation port
  fcs_op_if.arr     op
);

  logic [DATA_W-1:0] mem [WORDS];
  logic              fail_q;

  function automatic logic [ADDR_W-2:0] word_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:1];
  endfunction

  // reset stands in for a shipped, fully erased part
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (op.start && op.erase) begin
      for (int i = 0; i < BLOCK_WORDS; i++) begin
        mem[{op.addr[ADDR_W-1:BLOCK_SHIFT], (BLOCK_SHIFT-1)'(i)}] <= ERASED_WORD;
      end
    end else if (op.start) begin
      mem[word_of(op.addr)] <= mem[word_of(op.addr)] & op.wdata;
    end
  end

  // verify outcome, held until the next operation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
    end else if (op.start) begin
      fail_q <= !op.erase && (mem[word_of(op.addr)] != ERASED_WORD);
    end
  end

  assign op.fail  = fail_q;
  assign op.rdata = mem[word_of(op.raddr)];

endmodule

// ---- fcs_sequencer.sv ----
// Purpose: decodes command bus cycles and runs auto program / erase
// Assumes: bus strobes come from logic on CLOCK; one strobe per cycle
// Notes:   read data is answered one cycle after the read strobe
`timescale 1ns/1ps
module fcs_sequencer
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  // command bus from the cpu core
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  input  wire logic [ADDR_W-1:0] BUS_ADDR,
  input  wire logic [DATA_W-1:0] BUS_WDATA,
  output logic      [DATA_W-1:0] BUS_RDATA,
  output logic                   BUS_RVALID,
  // control register bits written by software
  input  wire logic              CPU_REWRITE_ENABLE,
  input  wire logic              LOW_BLOCK_REWRITE_PERMIT,
  input  wire logic              ERASE_WRITE_MODE_B,
  // control register bits mirroring the status byte
  output logic                   CTRL_READY_MIRROR,
  output logic                   CTRL_PROGRAM_FAIL_MIRROR,
  output logic                   CTRL_ERASE_FAIL_MIRROR,
  // status byte
  output logic      [7:0]        FLASH_STATUS_BYTE
);

  fcs_op_if op ();

  fcs_state_t      state_q;
  fcs_state_t      state_d;
  fcs_read_mode_t  rmode_q;
  logic            ready_q;
  logic            efail_q;
  logic            pfail_q;
  logic            busy_erase_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [DATA_W-1:0] op_data_q;
  logic            start_q;
  logic            op_done;
  logic [DATA_W-1:0] rdata_q;
  logic            rvalid_q;

  // decoded command cycle
  logic [7:0]      cmd_byte;
  logic            cmd_wr;
  logic            flags_block;
  logic            low_block_locked;
  logic            prog_go;
  logic            erase_go;
  logic            seq_error;
  logic            clear_flags;
  logic            to_array;
  logic            to_status;

  function automatic logic is_low_block(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLOCK_SHIFT] < BLOCK_W'(2);
  endfunction

  assign cmd_byte         = BUS_WDATA[7:0];
  assign cmd_wr           = BUS_WR && CPU_REWRITE_ENABLE && state_q != FCS_BUSY;
  assign flags_block      = efail_q || pfail_q;
  assign low_block_locked = !LOW_BLOCK_REWRITE_PERMIT && is_low_block(BUS_ADDR);

  // command decode
  always_comb begin
    state_d     = state_q;
    prog_go     = 1'b0;
    erase_go    = 1'b0;
    seq_error   = 1'b0;
    clear_flags = 1'b0;
    to_array    = 1'b0;
    to_status   = 1'b0;
    if (cmd_wr) begin
      case (state_q)
        FCS_IDLE: begin
          case (cmd_byte)
            CMD_READ_ARRAY: begin
              to_array = 1'b1;
            end
            CMD_READ_STATUS: begin
              to_status = 1'b1;
            end
            CMD_CLEAR_STAT: begin
              clear_flags = 1'b1;
            end
            CMD_PROGRAM: begin
              state_d = FCS_PROG_DATA;
            end
            CMD_ERASE_SETUP: begin
              state_d = FCS_ERASE_CONF;
            end
            default: begin
              seq_error = 1'b1;
              to_status = 1'b1;
            end
          endcase
        end
        FCS_PROG_DATA: begin
          // any 16-bit value is legal program data, even all ones
          state_d = FCS_IDLE;
          if (!flags_block && !low_block_locked) begin
            prog_go = 1'b1;
            state_d = FCS_BUSY;
          end
        end
        FCS_ERASE_CONF: begin
          state_d = FCS_IDLE;
          if (cmd_byte == CMD_READ_ARRAY) begin
            to_array = 1'b1;
          end else if (cmd_byte != CMD_ERASE_CONF) begin
            seq_error = 1'b1;
            to_status = 1'b1;
          end else if (!flags_block && !low_block_locked) begin
            erase_go = 1'b1;
            state_d  = FCS_BUSY;
          end
        end
        default: begin
          state_d = FCS_IDLE;
        end
      endcase
    end else if (state_q == FCS_BUSY && op_done) begin
      state_d = FCS_IDLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_q <= FCS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch the target of an accepted auto operation
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      op_addr_q    <= '0;
      op_data_q    <= ERASED_WORD;
      busy_erase_q <= 1'b0;
      start_q      <= 1'b0;
    end else begin
      start_q <= prog_go || erase_go;
      if (prog_go || erase_go) begin
        op_addr_q    <= BUS_ADDR;
        op_data_q    <= BUS_WDATA;
        busy_erase_q <= erase_go;
      end
    end
  end

  // ready bit: low from acceptance until the timer ends
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ready_q <= READY_RESET;
    end else if (prog_go || erase_go) begin
      ready_q <= 1'b0;
    end else if (op_done) begin
      ready_q <= 1'b1;
    end
  end

  // error flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      efail_q <= FAIL_RESET;
      pfail_q <= FAIL_RESET;
    end else begin
      if (seq_error) begin
        efail_q <= 1'b1;
        pfail_q <= 1'b1;
      end else if (op_done && op.fail) begin
        if (busy_erase_q) begin
          efail_q <= 1'b1;
        end else begin
          pfail_q <= 1'b1;
        end
      end else if (clear_flags) begin
        efail_q <= 1'b0;
        pfail_q <= 1'b0;
      end
    end
  end

  // read mode: status persists until read-array, or until rewrite mode is left
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rmode_q <= FCS_RD_ARRAY;
    end else if (!CPU_REWRITE_ENABLE || to_array) begin
      rmode_q <= FCS_RD_ARRAY;
    end else if (to_status || prog_go || erase_go) begin
      rmode_q <= FCS_RD_STATUS;
    end
  end

  // auto operation length
  fcs_op_timer u_timer (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .start    (start_q),
    .is_erase (busy_erase_q),
    .done     (op_done)
  );

  assign op.start = start_q;
  assign op.erase = busy_erase_q;
  assign op.addr  = op_addr_q;
  assign op.wdata = op_data_q;
  assign op.raddr = BUS_ADDR;

  fcs_flash_array u_array (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .op    (op.arr)
  );

  assign FLASH_STATUS_BYTE = {ready_q, 1'b0, efail_q, pfail_q, 4'h0};

  // read answer one cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= BUS_RD;
      if (BUS_RD) begin
        if (CPU_REWRITE_ENABLE && (rmode_q == FCS_RD_STATUS || state_q == FCS_BUSY)) begin
          rdata_q <= {8'h00, FLASH_STATUS_BYTE};
        end else begin
          rdata_q <= op.rdata;
        end
      end
    end
  end

  assign BUS_RDATA                = rdata_q;
  assign BUS_RVALID               = rvalid_q;
  assign CTRL_READY_MIRROR        = ready_q;
  assign CTRL_PROGRAM_FAIL_MIRROR = pfail_q;
  assign CTRL_ERASE_FAIL_MIRROR   = efail_q;

endmodule

// ---- fcs_sequencer_props.sv ----
// Purpose: concurrent checks on the sequencer top ports
// Assumes: one clock, synchronous active-low reset
// Notes:   second_q marks a pending second command cycle
`timescale 1ns/1ps
module fcs_sequencer_props
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic              CLOCK,
  input wire logic              RESET_N,
  // command bus
  input wire logic              BUS_WR,
  input wire logic              BUS_RD,
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic [DATA_W-1:0] BUS_WDATA,
  input wire logic [DATA_W-1:0] BUS_RDATA,
  input wire logic              BUS_RVALID,
  // control and status
  input wire logic              CPU_REWRITE_ENABLE,
  input wire logic              LOW_BLOCK_REWRITE_PERMIT,
  input wire logic              ERASE_WRITE_MODE_B,
  input wire logic              CTRL_READY_MIRROR,
  input wire logic              CTRL_PROGRAM_FAIL_MIRROR,
  input wire logic              CTRL_ERASE_FAIL_MIRROR,
  input wire logic [7:0]        FLASH_STATUS_BYTE
);
  logic        acc;
  logic        start_cmd;
  logic        second_q;
  logic [15:0] low_cnt_q;
  assign acc = BUS_WR && CPU_REWRITE_ENABLE && CTRL_READY_MIRROR;
  assign start_cmd = acc && second_q;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) second_q <= 1'b0;
    else if (acc) second_q <= !second_q && (BUS_WDATA[7:0] == CMD_PROGRAM || BUS_WDATA[7:0] == CMD_ERASE_SETUP);
  end
  // counts busy cycles so the exact length can be checked past the repetition limit
  always_ff @(posedge CLOCK) begin
    if (!RESET_N || CTRL_READY_MIRROR) low_cnt_q <= 16'h0000;
    else low_cnt_q <= low_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_read_answer: assert property (BUS_RD |=> BUS_RVALID) else $error("read not answered");
  a_rvalid_pulse: assert property (!BUS_RD |=> !BUS_RVALID) else $error("stray read valid");
  a_status_layout: assert property (FLASH_STATUS_BYTE[6] == 1'b0 && FLASH_STATUS_BYTE[3:0] == 4'h0
    && {CTRL_READY_MIRROR, CTRL_ERASE_FAIL_MIRROR, CTRL_PROGRAM_FAIL_MIRROR} == {FLASH_STATUS_BYTE[7],
    FLASH_STATUS_BYTE[5:4]}) else $error("status byte and mirrors disagree");
  a_clear_flags: assert property (acc && !second_q && BUS_WDATA[7:0] == CMD_CLEAR_STAT |=>
    FLASH_STATUS_BYTE[5:4] == 2'b00) else $error("clear left an error flag");
  a_busy_length: assert property ($rose(CTRL_READY_MIRROR) |->
    (low_cnt_q == PROG_CYCLES + 1 || low_cnt_q == ERASE_CYCLES + 1)) else $error("busy span wrong");
  a_busy_bound: assert property (low_cnt_q <= ERASE_CYCLES + 1) else $error("busy too long");
  a_start_cause: assert property ($fell(CTRL_READY_MIRROR) |-> $past(start_cmd))
    else $error("busy without a command");
  a_low_refused: assert property (acc && second_q && !LOW_BLOCK_REWRITE_PERMIT &&
    BUS_ADDR[11:10] == 2'b00 |=> CTRL_READY_MIRROR) else $error("low block accepted");
  a_error_refused: assert property (acc && second_q && FLASH_STATUS_BYTE[5:4] != 2'b00 |=>
    CTRL_READY_MIRROR) else $error("command accepted with error set");
  a_disabled_idle: assert property (BUS_WR && !CPU_REWRITE_ENABLE && CTRL_READY_MIRROR |=>
    $stable(FLASH_STATUS_BYTE)) else $error("write acted while disabled");
endmodule

// ---- fcs_cpu_model.sv ----
// Purpose: cpu core issuing command and read bus cycles
// Assumes: drives on the falling edge, one strobe cycle per access
// Notes:   idle bus shows inverted values so stale data never matches
`timescale 1ns/1ps
module fcs_cpu_model
  import fcs_pkg::*;
(
  // clock
  input wire logic              clk,
  // command bus
  output logic                  bus_wr,
  output logic                  bus_rd,
  output logic     [ADDR_W-1:0] bus_addr,
  output logic     [DATA_W-1:0] bus_wdata,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic              bus_rvalid
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 16'h0000;
  end
  task automatic idle();
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    bus_wr = 1'b1;
    bus_addr = {a[ADDR_W-1:1], 1'b0};
    bus_wdata = d;
    @(negedge clk);
    idle();
  endtask
  // valid stands only one cycle after the strobe edge, so take the answer at the next falling edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(negedge clk);
    bus_rd = 1'b1;
    bus_addr = {a[ADDR_W-1:1], 1'b0};
    @(negedge clk);
    v = bus_rvalid;
    d = bus_rdata;
    idle();
  endtask
  // upper command byte is junk on purpose; same address in both cycles
  task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(a, {8'hA5, CMD_PROGRAM});
    wr(a, d);
  endtask
  task automatic erase(input logic [ADDR_W-1:0] top);
    wr(top, {8'h3C, CMD_ERASE_SETUP});
    wr(top, {8'h00, CMD_ERASE_CONF});
  endtask
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for the flash command sequencer
// Assumes: cpu model drives the bus, bench drives control bits
// Notes:   auto operations run at full length
`timescale 1ns/1ps
module tb;
  import fcs_pkg::*;
  logic              CLOCK, RESET_N, BUS_WR, BUS_RD, BUS_RVALID;
  logic [ADDR_W-1:0] BUS_ADDR;
  logic [DATA_W-1:0] BUS_WDATA, BUS_RDATA, rdat;
  logic              CPU_REWRITE_ENABLE, LOW_BLOCK_REWRITE_PERMIT, ERASE_WRITE_MODE_B, rv;
  logic              CTRL_READY_MIRROR, CTRL_PROGRAM_FAIL_MIRROR, CTRL_ERASE_FAIL_MIRROR;
  logic [7:0]        FLASH_STATUS_BYTE;
  int                fail_count = 0;
  int                tests_run = 0;
  fcs_sequencer uut (.CLOCK(CLOCK), .RESET_N(RESET_N), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR),
    .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .CPU_REWRITE_ENABLE(CPU_REWRITE_ENABLE),
    .LOW_BLOCK_REWRITE_PERMIT(LOW_BLOCK_REWRITE_PERMIT), .ERASE_WRITE_MODE_B(ERASE_WRITE_MODE_B),
    .CTRL_READY_MIRROR(CTRL_READY_MIRROR), .CTRL_PROGRAM_FAIL_MIRROR(CTRL_PROGRAM_FAIL_MIRROR),
    .CTRL_ERASE_FAIL_MIRROR(CTRL_ERASE_FAIL_MIRROR), .FLASH_STATUS_BYTE(FLASH_STATUS_BYTE));
  fcs_cpu_model cpu (.clk(CLOCK), .bus_wr(BUS_WR), .bus_rd(BUS_RD), .bus_addr(BUS_ADDR), .bus_wdata(BUS_WDATA),
    .bus_rdata(BUS_RDATA), .bus_rvalid(BUS_RVALID));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    cpu.rd(a, rdat, rv);
    check({15'h0000, rv}, 16'h0001);
    check(rdat, exp);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic er,
                    input logic [DATA_W-1:0] st);
    int n;
    n = 0;
    if (er) cpu.erase(a);
    else cpu.prog(a, d);
    @(posedge CLOCK);
    #1;
    check({15'h0000, CTRL_READY_MIRROR}, 16'h0000);
    rd_chk(a, 16'h0000);
    cpu.wr(a, 16'h00FF);
    while (CTRL_READY_MIRROR !== 1'b1 && n < 3000) begin
      @(posedge CLOCK);
      n++;
    end
    rd_chk(a, st);
  endtask
  initial begin
    repeat (50000) @(posedge CLOCK);
    fail_count++;
    finish_test();
  end
  initial begin
    RESET_N = 1'b0;
    CPU_REWRITE_ENABLE = 1'b1;
    LOW_BLOCK_REWRITE_PERMIT = 1'b1;
    ERASE_WRITE_MODE_B = 1'b0;
    repeat (5) @(negedge CLOCK);
    RESET_N = 1'b1;
    check({8'h00, FLASH_STATUS_BYTE}, 16'h0080);
    cpu.wr(12'h400, 16'h00FF);
    rd_chk(12'h400, ERASED_WORD);
    cpu.wr(12'h400, 16'h5570);
    rd_chk(12'h402, 16'h0080);
    op(12'h400, 16'h1234, 1'b0, 16'h0080);
    cpu.wr(12'h400, 16'h00FF);
    rd_chk(12'h400, 16'h1234);
    rd_chk(12'h402, ERASED_WORD);
    // programmed word hit again on purpose: the only way to make verify fail
    op(12'h400, 16'h0000, 1'b0, 16'h0090);
    cpu.prog(12'h404, 16'h0000);
    rd_chk(12'h404, 16'h0090);
    cpu.wr(12'h404, 16'h0050);
    rd_chk(12'h404, 16'h0080);
    check({13'h0000, CTRL_READY_MIRROR, CTRL_ERASE_FAIL_MIRROR, CTRL_PROGRAM_FAIL_MIRROR}, 16'h0004);
    cpu.wr(12'h404, 16'h00FF);
    rd_chk(12'h404, ERASED_WORD);
    op(12'h500, 16'h5555, 1'b0, 16'h0080);
    op(12'h5FE, 16'h0000, 1'b1, 16'h0080);
    cpu.wr(12'h5FE, 16'h0050);
    rd_chk(12'h500, 16'h0080);
    cpu.wr(12'h5FE, 16'h00FF);
    rd_chk(12'h500, ERASED_WORD);
    rd_chk(12'h400, ERASED_WORD);
    cpu.wr(12'h5FE, 16'h0020);
    cpu.wr(12'h5FE, 16'h0012);
    rd_chk(12'h5FE, 16'h00B0);
    cpu.wr(12'h5FE, 16'h0050);
    cpu.wr(12'h5FE, 16'h1233);
    rd_chk(12'h5FE, 16'h00B0);
    cpu.wr(12'h5FE, 16'h0050);
    cpu.wr(12'h5FE, 16'h0020);
    cpu.wr(12'h5FE, 16'h00FF);
    rd_chk(12'h400, ERASED_WORD);
    @(negedge CLOCK);
    LOW_BLOCK_REWRITE_PERMIT = 1'b0;
    cpu.prog(12'h000, 16'h0000);
    rd_chk(12'h000, ERASED_WORD);
    @(negedge CLOCK);
    CPU_REWRITE_ENABLE = 1'b0;
    LOW_BLOCK_REWRITE_PERMIT = 1'b1;
    cpu.prog(12'h000, 16'h0000);
    check({15'h0000, CTRL_READY_MIRROR}, 16'h0001);
    rd_chk(12'h000, ERASED_WORD);
    finish_test();
  end
endmodule
bind fcs_sequencer fcs_sequencer_props chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
  .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID),
  .CPU_REWRITE_ENABLE(CPU_REWRITE_ENABLE), .LOW_BLOCK_REWRITE_PERMIT(LOW_BLOCK_REWRITE_PERMIT),
  .ERASE_WRITE_MODE_B(ERASE_WRITE_MODE_B), .CTRL_READY_MIRROR(CTRL_READY_MIRROR),
  .CTRL_PROGRAM_FAIL_MIRROR(CTRL_PROGRAM_FAIL_MIRROR), .CTRL_ERASE_FAIL_MIRROR(CTRL_ERASE_FAIL_MIRROR),
  .FLASH_STATUS_BYTE(FLASH_STATUS_BYTE));
